// [design/lvd_ctrl.v]
// Supply-monitor control: flags, interrupt request and low-voltage reset
//Contract
// (RULE1) After power-on reset detection is active, both interrupt enables cleared.
// (RULE2) Software clears both flags before setting an interrupt enable.
// (RULE3) After standby, power detector, select mode, wait 50 us, clear flags, enable.
// (RULE4) Internal fall: level low, fall flag set, request if fall enable.
// (RULE5) Internal rise without reset drop: level high; rise flag and request if enabled. The code also needs the rise enable set at the preceding fall.
// (RULE6) Reset-level drop with reset enable enters low-voltage reset.
// (RULE7) External mode: write select 0, wait 50 us, clear flags, enable.
// (RULE8) External fall pin trips: level low, fall flag, request if enabled.
// (RULE9) External rise pin trips, no reset drop: level high, rise flag if enabled. The code also needs the rise enable set at the preceding fall.
// (RULE10) Disable: clear reset and irq enables first, then power and reference.
// (RULE11) Never clear power or reference together with the enables.
// (RULE12) Enable: set power and reference, wait 50 us, clear flags, then enables.
// (RULE13) Flags clear only by writing 0 after reading them as 1.
// (RULE14) Reset release waits 131072 cycles; control bits keep values through it.
// (RULE15) Comparator outputs synchronised and edge detected; one set per crossing.
`timescale 1ns/1ns
`default_nettype none
`include "lvd_defines.vh"
module lvd_ctrl (
   input  wire clk,
   input  wire nrst,
   input  wire ctrl_wr,
   input  wire detector_power_enable_in,
   input  wire reference_enable_in,
   input  wire internal_compare_select_in,
   input  wire low_voltage_reset_enable_in,
   input  wire fall_irq_enable_in,
   input  wire rise_irq_enable_in,
   input  wire status_rd,
   input  wire status_wr,
   input  wire fall_flag_wdata,
   input  wire rise_flag_wdata,
   input  wire int_fall_cmp_n,
   input  wire int_rise_cmp,
   input  wire fall_compare_input,
   input  wire rise_compare_input,
   input  wire reset_cmp_n,
   output reg  detector_power_enable,
   output reg  reference_enable,
   output reg  internal_compare_select,
   output reg  low_voltage_reset_enable,
   output reg  fall_irq_enable,
   output reg  rise_irq_enable,
   output reg  supply_fall_flag,
   output reg  supply_rise_flag,
   output reg  low_voltage_level_n,
   output reg  external_irq_line_zero,
   output reg  low_voltage_reset_n
);
   wire ifall_fall;
   wire irise_rise;
   wire efall_fall;
   wire erise_rise;
   wire rst_lvl;
   wire fall_evt;
   wire rise_evt;
   wire rise_set;
   wire fall_clr;
   wire rise_clr;
   reg  [1:0] state_reg;
   reg  [1:0] state_next;
   reg  [`LVD_CNT_W-1:0] cnt_reg;
   reg  [`LVD_CNT_W-1:0] cnt_next;
   reg  fall_seen_reg;
   reg  rise_seen_reg;
   reg  reset_drop_reg;
   reg  armed_reg;

   // Sequencer states
   localparam [1:0] ST_RUN   = `LVD_ST_RUN;
   localparam [1:0] ST_HELD  = `LVD_ST_HELD;
   localparam [1:0] ST_COUNT = `LVD_ST_COUNT;

   // Picks the internal or the external comparator event
   function pick_src(input sel, input int_evt, input ext_evt);
      begin
         pick_src = sel ? int_evt : ext_evt;
      end
   endfunction

   // Comparator inputs; fall comparators are low when tripped
   lvd_sync_edge u_ifall ( // RULE15
      .clk        (clk),
      .nrst       (nrst),
      .async_in   (int_fall_cmp_n),
      .init_val   (1'b1),
      .level      (),
      .rise_pulse (),
      .fall_pulse (ifall_fall)
   );
   lvd_sync_edge u_irise ( // RULE15
      .clk        (clk),
      .nrst       (nrst),
      .async_in   (int_rise_cmp),
      .init_val   (1'b1),
      .level      (),
      .rise_pulse (irise_rise),
      .fall_pulse ()
   );
   lvd_sync_edge u_efall ( // RULE15
      .clk        (clk),
      .nrst       (nrst),
      .async_in   (fall_compare_input),
      .init_val   (1'b1),
      .level      (),
      .rise_pulse (),
      .fall_pulse (efall_fall)
   );
   lvd_sync_edge u_erise ( // RULE15
      .clk        (clk),
      .nrst       (nrst),
      .async_in   (rise_compare_input),
      .init_val   (1'b1),
      .level      (),
      .rise_pulse (erise_rise),
      .fall_pulse ()
   );
   lvd_sync_edge u_rst ( // RULE15
      .clk        (clk),
      .nrst       (nrst),
      .async_in   (reset_cmp_n),
      .init_val   (1'b1),
      .level      (rst_lvl),
      .rise_pulse (),
      .fall_pulse ()
   );

   // Mode select picks the comparator pair
   assign fall_evt = detector_power_enable &
                     pick_src(internal_compare_select, ifall_fall, efall_fall);
   // Level recovers on a rise with no reset drop; flag and request only when armed by a fall seen while the rise enable was set
   assign rise_evt = detector_power_enable & ~reset_drop_reg &
                     pick_src(internal_compare_select, irise_rise, erise_rise); // RULE9
   assign rise_set = rise_evt & armed_reg & rise_irq_enable; // RULE5 RULE9

   // Clear needs a prior read as one; a same-cycle set wins
   assign fall_clr = status_wr & ~fall_flag_wdata & fall_seen_reg; // RULE13
   assign rise_clr = status_wr & ~rise_flag_wdata & rise_seen_reg; // RULE13

   // Control bits: reset only by power-on reset, kept through low-voltage reset
   always @(posedge clk) begin
      if (!nrst) begin
         detector_power_enable    <= `LVD_CTRL_RESET; // RULE1
         reference_enable         <= `LVD_CTRL_RESET;
         internal_compare_select  <= `LVD_CTRL_RESET;
         low_voltage_reset_enable <= `LVD_CTRL_RESET;
         fall_irq_enable          <= `LVD_IRQ_EN_RESET; // RULE1
         rise_irq_enable          <= `LVD_IRQ_EN_RESET; // RULE1
      end else if (ctrl_wr) begin
         detector_power_enable    <= detector_power_enable_in; // RULE14
         reference_enable         <= reference_enable_in;
         internal_compare_select  <= internal_compare_select_in;
         low_voltage_reset_enable <= low_voltage_reset_enable_in;
         fall_irq_enable          <= fall_irq_enable_in;
         rise_irq_enable          <= rise_irq_enable_in;
      end
   end

   // Flags, read tracking and interrupt request
   always @(posedge clk) begin
      if (!nrst || !low_voltage_reset_n) begin
         supply_fall_flag       <= `LVD_FLAG_RESET;
         supply_rise_flag       <= `LVD_FLAG_RESET;
         fall_seen_reg          <= 1'b0;
         rise_seen_reg          <= 1'b0;
         low_voltage_level_n    <= 1'b1;
         external_irq_line_zero <= 1'b0;
         armed_reg              <= 1'b0;
      end else begin
         if (fall_evt) begin
            supply_fall_flag    <= 1'b1; // RULE4 RULE8
            low_voltage_level_n <= 1'b0; // RULE4 RULE8
            armed_reg           <= rise_irq_enable;
         end else if (fall_clr) begin
            supply_fall_flag <= 1'b0;
         end
         if (rise_evt) begin
            low_voltage_level_n <= 1'b1; // RULE5 RULE9
            armed_reg           <= 1'b0;
         end
         if (rise_set) begin
            supply_rise_flag <= 1'b1; // RULE5 RULE9
         end else if (rise_clr) begin
            supply_rise_flag <= 1'b0;
         end
         if (status_rd) begin
            fall_seen_reg <= supply_fall_flag;
            rise_seen_reg <= supply_rise_flag;
         end else if (status_wr) begin
            fall_seen_reg <= 1'b0;
            rise_seen_reg <= 1'b0;
         end
         external_irq_line_zero <= (fall_evt & fall_irq_enable) |
                                   rise_set; // RULE4 RULE5 RULE8 RULE9
      end
   end

   // Low-voltage reset sequencer
   always @* begin
      state_next = state_reg;
      cnt_next   = cnt_reg;
      case (state_reg)
         ST_RUN: begin
            if (!rst_lvl && low_voltage_reset_enable && detector_power_enable)
               state_next = ST_HELD; // RULE6
         end
         ST_HELD: begin
            if (rst_lvl) begin
               state_next = ST_COUNT;
               cnt_next   = `LVD_CNT_ZERO;
            end
         end
         ST_COUNT: begin
            if (!rst_lvl) begin
               state_next = ST_HELD;
            end else if (cnt_reg == `LVD_CNT_LAST) begin
               state_next = ST_RUN; // RULE14
            end else begin
               cnt_next = cnt_reg + `LVD_CNT_ONE;
            end
         end
         default: state_next = ST_RUN;
      endcase
   end

   always @(posedge clk) begin
      if (!nrst) begin
         state_reg           <= ST_RUN;
         cnt_reg             <= `LVD_CNT_ZERO;
         reset_drop_reg      <= 1'b0;
         low_voltage_reset_n <= 1'b1;
      end else begin
         state_reg           <= state_next;
         cnt_reg             <= cnt_next;
         low_voltage_reset_n <= (state_next == ST_RUN); // RULE6
         if (!rst_lvl)
            reset_drop_reg <= 1'b1; // RULE9
         else if (fall_evt)
            reset_drop_reg <= 1'b0;
      end
   end
endmodule // lvd_ctrl
`default_nettype wire

// [design/lvd_sync_edge.v]
// Two-stage synchroniser with rise and fall pulses
`timescale 1ns/1ns
`default_nettype none
module lvd_sync_edge (
   input  wire clk,
   input  wire nrst,
   input  wire async_in,
   input  wire init_val,
   output wire level,
   output wire rise_pulse,
   output wire fall_pulse
);
   reg meta_reg;
   reg sync_reg;
   reg last_reg;

   // Reset level is the safe value of the comparator
   always @(posedge clk) begin
      if (!nrst) begin
         meta_reg <= init_val;
         sync_reg <= init_val;
         last_reg <= init_val;
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   assign level      = sync_reg;
   assign rise_pulse = sync_reg & ~last_reg;
   assign fall_pulse = ~sync_reg & last_reg;
endmodule // lvd_sync_edge
`default_nettype wire

// [shared/lvd_defines.vh]
// Constants for the supply-monitor control block
`ifndef LVD_DEFINES_VH
`define LVD_DEFINES_VH
`define LVD_CLK_MHZ           25
`define LVD_RESET_HOLD_CYCLES 131072
`define LVD_CNT_W             18
`define LVD_CNT_ZERO          18'h00000
`define LVD_CNT_ONE           18'h00001
// Last count of the reset hold, one below the hold length
`define LVD_CNT_LAST          18'h1FFFF
`define LVD_CTRL_RESET        1'b1
`define LVD_IRQ_EN_RESET      1'b0
`define LVD_FLAG_RESET        1'b0
`define LVD_ST_RUN            2'h0
`define LVD_ST_HELD           2'h1
`define LVD_ST_COUNT          2'h2
`endif

// [test/lvd_cmp_model.sv]
// Comparator model for the supply and the external compare pins
`timescale 1ns/1ns
`default_nettype none
module lvd_cmp_model (
   input  wire [1:0] supply_state,
   input  wire       ext_mode,
   output wire       int_fall_cmp_n,
   output wire       int_rise_cmp,
   output wire       fall_compare_input,
   output wire       rise_compare_input,
   output wire       reset_cmp_n
);
   // State 0 above rise level, 1 below fall level, 2 below reset level
   assign int_fall_cmp_n     = (supply_state == 2'h0);
   assign int_rise_cmp       = (supply_state == 2'h0);
   // Pins rest above threshold unless external mode makes them follow
   assign fall_compare_input = !ext_mode || (supply_state == 2'h0);
   assign rise_compare_input = !ext_mode || (supply_state == 2'h0);
   assign reset_cmp_n        = (supply_state != 2'h2);
endmodule // lvd_cmp_model
`default_nettype wire

// [test/lvd_ctrl_monitor.sv]
// Assertions on the supply-monitor control ports
`timescale 1ns/1ns
`default_nettype none
module lvd_ctrl_monitor (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ctrl_wr,
   input wire logic status_wr,
   input wire logic fall_flag_wdata,
   input wire logic reset_cmp_n,
   input wire logic int_fall_cmp_n,
   input wire logic internal_compare_select,
   input wire logic detector_power_enable,
   input wire logic reference_enable,
   input wire logic low_voltage_reset_enable,
   input wire logic fall_irq_enable,
   input wire logic rise_irq_enable,
   input wire logic detector_power_enable_in,
   input wire logic supply_fall_flag,
   input wire logic supply_rise_flag,
   input wire logic low_voltage_level_n,
   input wire logic external_irq_line_zero,
   input wire logic low_voltage_reset_n
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence s_fall_trip;
      $fell(int_fall_cmp_n) && internal_compare_select && detector_power_enable
         && low_voltage_reset_n;
   endsequence
   sequence s_fall_seen;
      supply_fall_flag && !low_voltage_level_n;
   endsequence
   a_irq_en_off: assert property ($rose(nrst) |-> !fall_irq_enable && !rise_irq_enable)
      else $error("irq enable set after reset");
   a_fall_set: assert property (s_fall_trip |-> ##[1:6] s_fall_seen)
      else $error("fall not flagged");
   a_fall_irq: assert property ($rose(supply_fall_flag) && fall_irq_enable |-> external_irq_line_zero)
      else $error("fall request missing");
   a_level_low: assert property ($fell(low_voltage_level_n) |-> supply_fall_flag)
      else $error("level low without flag");
   a_rise_flag: assert property ($rose(supply_rise_flag) |-> rise_irq_enable
      && low_voltage_level_n && external_irq_line_zero)
      else $error("rise flag without cause");
   a_clear_cause: assert property ($fell(supply_fall_flag) && low_voltage_reset_n
      && $past(low_voltage_reset_n) |-> $past(status_wr) && !$past(fall_flag_wdata))
      else $error("flag cleared without write");
   a_ctrl_load: assert property (ctrl_wr && low_voltage_reset_n
      |=> detector_power_enable == $past(detector_power_enable_in))
      else $error("control write lost");
   a_reset_entry: assert property ($fell(reset_cmp_n) && low_voltage_reset_enable
      && detector_power_enable |-> ##[1:5] !low_voltage_reset_n)
      else $error("reset not entered");
   a_reset_hold: assert property ($fell(low_voltage_reset_n) |-> !low_voltage_reset_n [*8])
      else $error("reset released early");
   a_ctrl_keep: assert property ($fell(low_voltage_reset_n) |-> $stable(detector_power_enable)
      && $stable(reference_enable) && $stable(low_voltage_reset_enable))
      else $error("control bits lost in reset");
endmodule // lvd_ctrl_monitor
bind lvd_ctrl lvd_ctrl_monitor u_lvd_ctrl_monitor (.*);
`default_nettype wire

// [test/lvd_ctrl_tb.sv]
// Self-checking bench for the supply-monitor control block
`timescale 1ns/1ns
`default_nettype none
module lvd_ctrl_tb;
   reg clk = 1'b0, nrst = 1'b0, ctrl_wr = 1'b0, status_rd = 1'b0, status_wr = 1'b0, m;
   reg [1:0] fw = 2'b00;
   reg [5:0] cw = 6'h00;
   reg [1:0] sup = 2'h0, en;
   reg [2:0] e;
   reg [2:0] q[$];
   wire ifn, ir, fc, rc, rcn, dpe, re, ics, lvre, fie, rie, ff, rf, lvl, irq, rn;
   integer bad_count = 0, num_checks = 0, seed = 22863, i, r;
   always #20 clk = ~clk;
   lvd_cmp_model u_lvd_cmp_model (.supply_state(sup), .ext_mode(!ics), .int_fall_cmp_n(ifn),
      .int_rise_cmp(ir), .fall_compare_input(fc), .rise_compare_input(rc), .reset_cmp_n(rcn));
   lvd_ctrl u_lvd_ctrl (.clk(clk), .nrst(nrst), .ctrl_wr(ctrl_wr),
      .detector_power_enable_in(cw[5]), .reference_enable_in(cw[4]),
      .internal_compare_select_in(cw[3]), .low_voltage_reset_enable_in(cw[2]),
      .fall_irq_enable_in(cw[1]), .rise_irq_enable_in(cw[0]), .status_rd(status_rd),
      .status_wr(status_wr), .fall_flag_wdata(fw[1]), .rise_flag_wdata(fw[0]),
      .int_fall_cmp_n(ifn), .int_rise_cmp(ir), .fall_compare_input(fc),
      .rise_compare_input(rc), .reset_cmp_n(rcn), .detector_power_enable(dpe),
      .reference_enable(re), .internal_compare_select(ics), .low_voltage_reset_enable(lvre),
      .fall_irq_enable(fie), .rise_irq_enable(rie), .supply_fall_flag(ff),
      .supply_rise_flag(rf), .low_voltage_level_n(lvl), .external_irq_line_zero(irq),
      .low_voltage_reset_n(rn));
   task automatic chk(input [10:0] exp, input [10:0] got); begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
         bad_count = bad_count + 1;
         $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
      end
   end endtask
   task cyc(input integer n); begin
      repeat (n) @(posedge clk);
      #1;
   end
   endtask
   task wr(input [5:0] v); begin
      cw = v;
      ctrl_wr = 1'b1;
      cyc(1);
      ctrl_wr = 1'b0;
      cyc(1);
      chk({5'h00, v}, {5'h00, dpe, re, ics, lvre, fie, rie});
   end
   endtask
   // Read the flags, then write both with the given value
   task clr(input d); begin
      status_rd = 1'b1;
      cyc(1);
      status_rd = 1'b0;
      fw = {d, d};
      status_wr = 1'b1;
      cyc(1);
      status_wr = 1'b0;
      fw = 2'b00;
      cyc(1);
   end
   endtask
   task final_report; begin
      if (bad_count == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   end
   endtask
   // Each request pulse is paired with the oldest note, looked at mid-cycle
   always @(negedge clk) begin
      if (irq === 1'b1) begin
         if (q.size() == 0) begin
            e = ~{lvl, ff, rf};
         end else begin
            e = q.pop_front();
         end
         chk({8'h00, e}, {8'h00, lvl, ff, rf});
      end
   end
   initial begin
      cyc(2);
      nrst = 1'b1;
      chk(11'h785, {dpe, re, ics, lvre, fie, rie, ff, rf, lvl, irq, rn});
      for (i = 0; i < 6; i = i + 1) begin
         m = ~i[0];
         r = $random(seed);
         en = r[1:0];
         wr({2'b11, m, 3'b000});
         cyc(1250);
         clr(1'b0);
         wr({2'b11, m, 1'b0, en});
         if (en[1]) begin
            q.push_back(3'h2);
         end
         sup = 2'h1;
         cyc(6);
         chk(11'h001, {9'h000, lvl, ff});
         clr(1'b1);
         chk(11'h001, {10'h000, ff});
         status_wr = 1'b1;
         cyc(1);
         status_wr = 1'b0;
         cyc(1);
         chk(11'h001, {10'h000, ff});
         clr(1'b0);
         cyc(6);
         chk(11'h000, {10'h000, ff});
         if (en[0]) begin
            q.push_back(3'h5);
         end
         sup = 2'h0;
         cyc(6);
         chk({8'h00, 2'b10, en[0]}, {8'h00, lvl, ff, rf});
         clr(1'b0);
         wr({2'b11, m, 3'b000});
         wr({2'b00, m, 3'b000});
      end
      wr(6'h38);
      cyc(1250);
      clr(1'b0);
      wr(6'h3C);
      sup = 2'h2;
      cyc(16);
      chk(11'h03C, {4'h0, rn, dpe, re, ics, lvre, fie, rie});
      chk(11'h000, {10'h000, q.size() != 0});
      final_report;
   end
endmodule // lvd_ctrl_tb
`default_nettype wire
